// file: common/liu_cfg_pkg.sv
// Shared types and constants for the line-interface pin configuration block.
package liu_cfg_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;

    // Reset value and writable mask of the control register.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK  = 32'h007F_FFFF;

    // Field positions in the status register; the low bits mirror ctrl_s.
    localparam int STATUS_HW_MODE_BIT  = 24;
    localparam int STATUS_SENS_LSB     = 25;
    localparam int STATUS_TRISTATE_BIT = 27;

    // Synthesized bit-clock rate codes.
    localparam logic [1:0] SYNTH_2048K  = 2'h0;
    localparam logic [1:0] SYNTH_4096K  = 2'h1;
    localparam logic [1:0] SYNTH_8192K  = 2'h2;
    localparam logic [1:0] SYNTH_16384K = 2'h3;

    // Monitor gain boost in dB and receive termination in ohms.
    localparam logic [5:0] BOOST_NONE_DB = 6'h00;
    localparam logic [5:0] BOOST_LOW_DB  = 6'h14;
    localparam logic [5:0] BOOST_MID_DB  = 6'h1A;
    localparam logic [5:0] BOOST_HIGH_DB = 6'h20;
    localparam logic [6:0] TERM_OFF_OHM  = 7'h00;
    localparam logic [6:0] TERM_120_OHM  = 7'h78;
    localparam logic [6:0] TERM_100_OHM  = 7'h64;
    localparam logic [6:0] TERM_75_OHM   = 7'h4B;

    // Receive sensitivity setting derived from gain limit and line type.
    typedef enum logic [1:0] {
        SENS_E1_12DB,
        SENS_E1_43DB,
        SENS_T1_30DB,
        SENS_T1_36DB
    } sens_e;

    // Internal control bits, the same layout as the control register.
    typedef struct packed {
        logic [1:0] synth_clock_sel;
        logic       carrier_pin_sel;
        logic       nonreturn_enable;
        logic       remote_loop_bit;
        logic       local_loop_bit;
        logic       analog_loop_bit;
        logic       send_all_ones;
        logic       send_alternating;
        logic       send_prbs;
        logic       gain_limit;
        logic       e1_t1_select;
        logic [1:0] monitor_gain;
        logic [1:0] termination;
        logic       rx_zero_sub_enable;
        logic       tx_zero_sub_enable;
        logic       rx_sync_clock_enable;
        logic       tx_sync_clock_enable;
        logic       tx_edge_select;
        logic       rx_edge_select;
        logic       jitter_depth_select;
    } ctrl_s;

    localparam int CTRL_W = $bits(ctrl_s);

    // Every input that arrives from outside the clock domain.
    typedef struct packed {
        logic rx_clock;
        logic rx_line_pos;
        logic rx_line_neg;
        logic rx_line_error;
        logic tx_clock;
        logic tx_pos_data;
        logic tx_neg_data;
        logic tx_power_down;
        logic test_tristate;
        logic nonreturn_enable;
        logic clock_edge_select;
        logic sync_clock_enable;
        logic zero_sub_enable_pin;
        logic loop_select_hi;
        logic loop_select_lo;
        logic tx_source_hi;
        logic tx_source_lo;
        logic monitor_gain_hi;
        logic monitor_gain_lo;
        logic termination_hi;
        logic termination_lo;
        logic interface_select_hi;
        logic interface_select_lo;
        logic carrier_loss_in;
        logic tx_clock_loss_in;
    } pins_s;

endpackage

// file: hw/line_interface_pin_config.sv
// Hardware-mode pin decode and system-side data timing of the line interface.
// How it works
// - Receive outputs update on rising clock edge if edge select 0, else falling.
// - NRZ mode: data on positive output, error pulse on negative output.
// - Transmit inputs sampled on falling clock edge if select 0, else rising.
// - Tri-state test input high releases every output and two-way pin.
// - Transmit power-down high tri-states both line driver outputs.
// - Sync-clock enable pin turns the 2.048MHz sync mode off or on.
// - Loop pins: 11 remote, 10 local, 01 analog, 00 no loopback.
// - Source pins: 11 all ones, 10 alternating, 01 PRBS, 00 data.
// - Sensitivity from gain limit and E1/T1: -12/-43 E1, -36/-30 T1.
// - Monitor gain bits give boost of 0, 20, 26 or 32 dB.
// - Termination bits: off, 120, 100 or 75 ohm.
// - Both interface-select pins high enter hardware mode using pin controls.
// - Hardware mode sets the synthesized bit clock to 16.384MHz.
// - Hardware mode routes carrier loss to the shared alarm pin.
// - Hardware mode holds the jitter depth select at 0.
// - One zero-substitution pin drives both receive and transmit enables.
// - One sync-clock pin drives both receive and transmit sync enables.
// - One edge-select pin drives both receive and transmit edge selects.
// - Hardware mode holds every unmapped control bit except the synthesized clock select at 0.
// - NRZ enable pin selects NRZ or bipolar form on both pin pairs.
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module line_interface_pin_config
    import liu_cfg_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        rx_clock,
    input  wire logic        rx_line_pos,
    input  wire logic        rx_line_neg,
    input  wire logic        rx_line_error,
    input  wire logic        tx_clock,
    input  wire logic        tx_pos_data,
    input  wire logic        tx_neg_data,
    input  wire logic        tx_power_down,
    input  wire logic        test_tristate,
    input  wire logic        nonreturn_enable,
    input  wire logic        clock_edge_select,
    input  wire logic        sync_clock_enable,
    input  wire logic        zero_sub_enable_pin,
    input  wire logic        loop_select_hi,
    input  wire logic        loop_select_lo,
    input  wire logic        tx_source_hi,
    input  wire logic        tx_source_lo,
    input  wire logic        monitor_gain_hi,
    input  wire logic        monitor_gain_lo,
    input  wire logic        termination_hi,
    input  wire logic        termination_lo,
    input  wire logic        interface_select_hi,
    input  wire logic        interface_select_lo,
    input  wire logic        carrier_loss_in,
    input  wire logic        tx_clock_loss_in,
    output logic             rx_pos_data,
    output logic             rx_neg_data,
    output logic             rx_data_oe,
    output logic             line_drive_a,
    output logic             line_drive_b,
    output logic             line_drive_oe,
    output logic             alarm_pin,
    output logic             alarm_pin_oe,
    output ctrl_s            control,
    output sens_e            sensitivity,
    output logic      [5:0]  gain_boost_db,
    output logic      [6:0]  termination_ohm,
    output logic             hw_mode
);

    pins_s      pin_raw;
    pins_s      pin_meta;
    pins_s      pin;
    logic       rx_clk_d;
    logic       tx_clk_d;
    logic       rx_take;
    logic       tx_take;
    logic [31:0] ctrl_word;
    logic       bus_done;
    ctrl_s      eff;
    logic       tx_mark;
    logic       ami_polarity;
    logic       alt_phase;
    logic [14:0] prbs;
    logic       nrz_mode;

    // Gather the pins so one synchroniser handles them all.
    assign pin_raw = '{rx_clock, rx_line_pos, rx_line_neg, rx_line_error,
                       tx_clock, tx_pos_data, tx_neg_data, tx_power_down,
                       test_tristate, nonreturn_enable, clock_edge_select,
                       sync_clock_enable, zero_sub_enable_pin,
                       loop_select_hi, loop_select_lo, tx_source_hi,
                       tx_source_lo, monitor_gain_hi, monitor_gain_lo,
                       termination_hi, termination_lo, interface_select_hi,
                       interface_select_lo, carrier_loss_in,
                       tx_clock_loss_in};

    // Two flip-flops per pin; only the second stage is read by logic.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta <= '0;
            pin      <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin      <= pin_meta;
        end
    end

    // Delayed copies of the synchronised clocks for edge detection.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_clk_d <= 1'b0;
            tx_clk_d <= 1'b0;
        end else begin
            rx_clk_d <= pin.rx_clock;
            tx_clk_d <= pin.tx_clock;
        end
    end

    assign hw_mode = pin.interface_select_hi & pin.interface_select_lo;

    // Effective controls are combinational so pin changes apply at once.
    // continuous pin decode
    always_comb begin
        eff = ctrl_s'(ctrl_word[CTRL_W-1:0]);
        if (hw_mode) begin
            eff = '0;
            eff.synth_clock_sel = SYNTH_16384K;
            eff.carrier_pin_sel = 1'b0;
            eff.jitter_depth_select = 1'b0;
            eff.nonreturn_enable = pin.nonreturn_enable;
            eff.remote_loop_bit = pin.loop_select_hi & pin.loop_select_lo;
            eff.local_loop_bit  = pin.loop_select_hi & ~pin.loop_select_lo;
            eff.analog_loop_bit = ~pin.loop_select_hi & pin.loop_select_lo;
            eff.send_all_ones    = pin.tx_source_hi & pin.tx_source_lo;
            eff.send_alternating = pin.tx_source_hi & ~pin.tx_source_lo;
            eff.send_prbs        = ~pin.tx_source_hi & pin.tx_source_lo;
            eff.monitor_gain = {pin.monitor_gain_hi, pin.monitor_gain_lo};
            eff.termination  = {pin.termination_hi, pin.termination_lo};
            eff.rx_zero_sub_enable = pin.zero_sub_enable_pin;
            eff.tx_zero_sub_enable = pin.zero_sub_enable_pin;
            eff.rx_sync_clock_enable = pin.sync_clock_enable;
            eff.tx_sync_clock_enable = pin.sync_clock_enable;
            eff.rx_edge_select = pin.clock_edge_select;
            eff.tx_edge_select = pin.clock_edge_select;
        end
    end

    assign control  = eff;
    assign nrz_mode = eff.nonreturn_enable;

    always_comb begin
        case ({eff.e1_t1_select, eff.gain_limit})
            2'b00:   sensitivity = SENS_E1_12DB;
            2'b01:   sensitivity = SENS_E1_43DB;
            2'b11:   sensitivity = SENS_T1_30DB;
            default: sensitivity = SENS_T1_36DB;
        endcase
    end

    always_comb begin
        case (eff.monitor_gain)
            2'b01:   gain_boost_db = BOOST_LOW_DB;
            2'b10:   gain_boost_db = BOOST_MID_DB;
            2'b11:   gain_boost_db = BOOST_HIGH_DB;
            default: gain_boost_db = BOOST_NONE_DB;
        endcase
    end

    always_comb begin
        case (eff.termination)
            2'b01:   termination_ohm = TERM_120_OHM;
            2'b10:   termination_ohm = TERM_100_OHM;
            2'b11:   termination_ohm = TERM_75_OHM;
            default: termination_ohm = TERM_OFF_OHM;
        endcase
    end

    assign rx_take = eff.rx_edge_select ? (rx_clk_d & ~pin.rx_clock)
                                        : (~rx_clk_d & pin.rx_clock);
    assign tx_take = eff.tx_edge_select ? (~tx_clk_d & pin.tx_clock)
                                        : (tx_clk_d & ~pin.tx_clock);

    // Receive outputs move only on the selected receive clock edge.
    // NRZ data and error
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_pos_data <= 1'b0;
            rx_neg_data <= 1'b0;
        end else if (rx_take) begin
            if (nrz_mode) begin
                rx_pos_data <= pin.rx_line_pos | pin.rx_line_neg;
                rx_neg_data <= pin.rx_line_error;
            end else begin
                rx_pos_data <= pin.rx_line_pos;
                rx_neg_data <= pin.rx_line_neg;
            end
        end
    end

    // Pick the mark to send this bit; NRZ data may arrive on either input.
    always_comb begin
        if (eff.send_all_ones) begin
            tx_mark = 1'b1;
        end else if (eff.send_alternating) begin
            tx_mark = alt_phase;
        end else if (eff.send_prbs) begin
            tx_mark = prbs[14];
        end else begin
            tx_mark = pin.tx_pos_data | pin.tx_neg_data;
        end
    end

    // Pattern state advances once per transmit bit.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            alt_phase <= 1'b1;
            prbs      <= 15'h7FFF;
        end else if (tx_take) begin
            alt_phase <= ~alt_phase;
            prbs      <= {prbs[13:0], prbs[14] ^ prbs[13]};
        end
    end

    // Line drivers take data at the transmit edge; generated patterns and
    // NRZ input are turned into alternating marks so the line stays balanced.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            line_drive_a <= 1'b0;
            line_drive_b <= 1'b0;
            ami_polarity <= 1'b0;
        end else if (tx_take) begin
            if (!nrz_mode && !eff.send_all_ones && !eff.send_alternating
                && !eff.send_prbs) begin
                line_drive_a <= pin.tx_pos_data;
                line_drive_b <= pin.tx_neg_data;
            end else begin
                line_drive_a <= tx_mark & ~ami_polarity;
                line_drive_b <= tx_mark & ami_polarity;
                ami_polarity <= ami_polarity ^ tx_mark;
            end
        end
    end

    // Shared alarm pin shows carrier loss or transmit clock loss.
    assign alarm_pin = eff.carrier_pin_sel ? pin.tx_clock_loss_in
                                           : pin.carrier_loss_in;

    assign rx_data_oe    = ~pin.test_tristate;
    assign alarm_pin_oe  = ~pin.test_tristate;
    assign line_drive_oe = ~pin.test_tristate & ~pin.tx_power_down;

    // Bus answers every request after exactly one wait cycle.
    assign waitrequest = (read | write) & ~bus_done;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus_done <= 1'b0;
        end else begin
            bus_done <= (read | write) & ~bus_done;
        end
    end

    // Control register write, byte lanes honoured, reserved bits kept 0.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_word <= CTRL_RESET;
        end else if (write && bus_done && address == CTRL_OFFSET) begin
            for (int i = 0; i < 4; i++) begin
                if (byteenable[i]) begin
                    ctrl_word[8*i +: 8] <= writedata[8*i +: 8] & CTRL_MASK[8*i +: 8];
                end
            end
        end
    end

    // Read data is captured in the wait cycle and stands in the answer one.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            readdata <= '0;
        end else if (read && !bus_done) begin
            case (address)
                CTRL_OFFSET: readdata <= ctrl_word;
                STATUS_OFFSET: begin
                    readdata <= '0;
                    readdata[CTRL_W-1:0] <= eff;
                    readdata[STATUS_HW_MODE_BIT] <= hw_mode;
                    readdata[STATUS_SENS_LSB +: 2] <= sensitivity;
                    readdata[STATUS_TRISTATE_BIT] <= pin.test_tristate;
                end
                default: readdata <= '0;
            endcase
        end
    end

    // Checks on the block's own outputs.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    rx_edge_only_a: assert property (
        !$past(rx_take) |-> $stable(rx_pos_data) && $stable(rx_neg_data))
        else $error("Receive output moved off the selected edge.");

    nrz_data_a: assert property (
        rx_take && nrz_mode |=> rx_pos_data == $past(pin.rx_line_pos
                                                   | pin.rx_line_neg)
                                && rx_neg_data == $past(pin.rx_line_error))
        else $error("NRZ receive data or error pulse wrong.");

    tx_sample_a: assert property (
        tx_take && !nrz_mode && !eff.send_all_ones && !eff.send_alternating
        && !eff.send_prbs |=> line_drive_a == $past(pin.tx_pos_data)
                              && line_drive_b == $past(pin.tx_neg_data))
        else $error("Transmit data not taken at the selected edge.");

    test_tristate_a: assert property (
        pin.test_tristate |-> !rx_data_oe && !line_drive_oe && !alarm_pin_oe)
        else $error("Output driven during tri-state test.");

    power_down_a: assert property (
        pin.tx_power_down |-> !line_drive_oe)
        else $error("Line driver enabled while powered down.");

    loop_decode_a: assert property (
        hw_mode |-> $onehot0({eff.remote_loop_bit, eff.local_loop_bit,
                              eff.analog_loop_bit})
                    && eff.local_loop_bit == (pin.loop_select_hi
                                              && !pin.loop_select_lo))
        else $error("Loopback decode wrong.");

    all_ones_a: assert property (
        eff.send_all_ones && tx_take |=> (line_drive_a ^ line_drive_b)
            && line_drive_b == $past(ami_polarity))
        else $error("All-ones pattern did not alternate marks.");

    sens_map_a: assert property (
        eff.e1_t1_select && !eff.gain_limit |-> sensitivity == SENS_T1_36DB)
        else $error("T1 sensitivity wrong.");

    hw_default_a: assert property (
        hw_mode |-> eff.synth_clock_sel == SYNTH_16384K
                    && !eff.jitter_depth_select && !eff.gain_limit
                    && alarm_pin == pin.carrier_loss_in)
        else $error("Hardware-mode defaults wrong.");

    tied_bits_a: assert property (
        hw_mode |-> eff.rx_edge_select == eff.tx_edge_select
                    && eff.rx_sync_clock_enable == eff.tx_sync_clock_enable
                    && eff.rx_zero_sub_enable == eff.tx_zero_sub_enable)
        else $error("Combined control bits disagree.");

    bus_answer_a: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("Bus answer late.");

    nrz_rx_c: cover property (rx_take && nrz_mode && pin.rx_line_error);
    hw_prbs_c: cover property (hw_mode && eff.send_prbs && tx_take);
    falling_rx_c: cover property (hw_mode && eff.rx_edge_select && rx_take);
    tristate_c: cover property (pin.test_tristate ##1 !pin.test_tristate);

endmodule

// file: verification/link_framer_model.sv
// Far-side framer model: link clocks, receive symbols and transmit data.
`timescale 1ns/100ps
module link_framer_model (
    input  wire logic run,
    input  wire logic edge_sel,
    output logic      rx_clock,
    output logic      rx_line_pos,
    output logic      rx_line_neg,
    output logic      rx_line_error,
    output logic      tx_clock,
    output logic      tx_pos_data,
    output logic      tx_neg_data
);
    // Random line symbol: space, positive or negative mark, never both.
    function automatic logic [1:0] symbol();
        int r;
        r = $urandom % 3;
        return (r == 0) ? 2'b00 : ((r == 1) ? 2'b10 : 2'b01);
    endfunction

    // Receive clock runs only within a burst and always rests low.
    initial begin
        {rx_line_pos, rx_line_neg, rx_line_error} = 3'h0;
        rx_clock = 1'b0;
        #37;
        forever begin
            #400;
            if (run || rx_clock)
                rx_clock = ~rx_clock;
        end
    end

    // Transmit clock has its own phase, unrelated to the system clock.
    initial begin
        {tx_pos_data, tx_neg_data} = 2'h0;
        tx_clock = 1'b0;
        #213;
        forever begin
            #400;
            if (run || tx_clock)
                tx_clock = ~tx_clock;
        end
    end

    // Receive data moves late in the period, far from the update edge.
    always @(rx_clock)
        if (rx_clock !== edge_sel) begin
            #600;
            {rx_line_pos, rx_line_neg} = symbol();
            rx_line_error = ($urandom % 4) == 0;
        end

    always @(tx_clock)
        if (tx_clock === edge_sel) begin
            #600;
            {tx_pos_data, tx_neg_data} = symbol();
        end
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the line-interface pin configuration block.
`timescale 1ns/100ps
module tb_top
    import liu_cfg_pkg::*;
;
    typedef struct packed {
        logic [2:0]  kind;
        logic [31:0] due;
        logic [38:0] val;
    } note_s;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [3:0]  address = 4'h0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [17:0] pv = 18'h0;
    wire tx_power_down, test_tristate, nonreturn_enable, clock_edge_select,
         sync_clock_enable, zero_sub_enable_pin, loop_select_hi,
         loop_select_lo, tx_source_hi, tx_source_lo, monitor_gain_hi,
         monitor_gain_lo, termination_hi, termination_lo,
         interface_select_hi, interface_select_lo, carrier_loss_in,
         tx_clock_loss_in;
    logic rx_clock, rx_line_pos, rx_line_neg, rx_line_error, tx_clock,
          tx_pos_data, tx_neg_data, rx_pos_data, rx_neg_data, rx_data_oe,
          line_drive_a, line_drive_b, line_drive_oe, alarm_pin,
          alarm_pin_oe, hw_mode;
    ctrl_s       control;
    sens_e       sensitivity;
    logic [5:0]  gain_boost_db;
    logic [6:0]  termination_ohm;
    note_s       q[$];
    logic        link_on = 1'b0;
    logic [31:0] cyc = 32'h0;
    int          err_total = 0;
    int          n_compared = 0;
    ctrl_s       creg = '0;
    logic [5:0]  boost_t[4] = '{BOOST_NONE_DB, BOOST_LOW_DB, BOOST_MID_DB,
                                BOOST_HIGH_DB};
    logic [6:0]  term_t[4] = '{TERM_OFF_OHM, TERM_120_OHM, TERM_100_OHM,
                               TERM_75_OHM};

    // Configuration pins all come from one vector the bench drives.
    assign {tx_power_down, test_tristate, nonreturn_enable, clock_edge_select,
            sync_clock_enable, zero_sub_enable_pin, loop_select_hi,
            loop_select_lo, tx_source_hi, tx_source_lo, monitor_gain_hi,
            monitor_gain_lo, termination_hi, termination_lo,
            interface_select_hi, interface_select_lo, carrier_loss_in,
            tx_clock_loss_in} = pv;

    line_interface_pin_config dut_u (.*);
    link_framer_model framer_u (.run(link_on), .edge_sel(clock_edge_select),
        .rx_clock, .rx_line_pos, .rx_line_neg, .rx_line_error, .tx_clock,
        .tx_pos_data, .tx_neg_data);

    // System clock and a cycle count used to time each note.
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 32'h1;

    function automatic sens_e sens_of(ctrl_s c);
        if (c.gain_limit)
            return c.e1_t1_select ? SENS_T1_30DB : SENS_E1_43DB;
        return c.e1_t1_select ? SENS_T1_36DB : SENS_E1_12DB;
    endfunction

    function automatic logic [38:0] full(ctrl_s c, logic hw);
        return {c, sens_of(c), boost_t[c.monitor_gain],
                term_t[c.termination], hw};
    endfunction

    // Controls expected from the pin vector in hardware mode.
    function automatic ctrl_s hwx(logic [17:0] v);
        ctrl_s c;
        c = '0;
        c.synth_clock_sel = SYNTH_16384K;
        c.nonreturn_enable = v[15];
        c.remote_loop_bit = v[11] & v[10];
        c.local_loop_bit = v[11] & ~v[10];
        c.analog_loop_bit = ~v[11] & v[10];
        c.send_all_ones = v[9] & v[8];
        c.send_alternating = v[9] & ~v[8];
        c.send_prbs = ~v[9] & v[8];
        c.monitor_gain = v[7:6];
        c.termination = v[5:4];
        {c.rx_zero_sub_enable, c.tx_zero_sub_enable} = {2{v[12]}};
        {c.rx_sync_clock_enable, c.tx_sync_clock_enable} = {2{v[13]}};
        {c.tx_edge_select, c.rx_edge_select} = {2{v[14]}};
        return c;
    endfunction

    function automatic logic [38:0] obs(logic [2:0] k);
        case (k)
            3'h0: return {control, sensitivity, gain_boost_db,
                          termination_ohm, hw_mode};
            3'h1: return {37'h0, rx_pos_data, rx_neg_data};
            3'h2: return {37'h0, line_drive_a, line_drive_b};
            3'h3: return {35'h0, rx_data_oe, line_drive_oe, alarm_pin_oe,
                          alarm_pin};
            default: return {7'h0, readdata};
        endcase
    endfunction

    function automatic logic [38:0] rx_exp();
        return {37'h0, nonreturn_enable ? {rx_line_pos | rx_line_neg,
                rx_line_error} : {rx_line_pos, rx_line_neg}};
    endfunction

    task automatic push(logic [2:0] k, logic [38:0] v, logic [31:0] due);
        q.push_back('{k, due, v});
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Bus cycle held until waitrequest is seen low at a rising edge.
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
        int n;
        @(posedge clk_sys);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) begin
            err_total++;
            conclude();
        end
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (q.size() > 0 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        if (q.size() > 0) begin
            err_total++;
            conclude();
        end
    endtask

    // Link notes: what the far side offers at each selected edge; transmit notes only outside NRZ mode.
    always @(rx_clock)
        if (link_on && rx_clock !== clock_edge_select)
            push(3'h1, rx_exp(), cyc + 32'h5);
    always @(tx_clock)
        if (link_on && !nonreturn_enable && tx_clock === clock_edge_select)
            push(3'h2, {37'h0, tx_pos_data, tx_neg_data}, cyc + 32'h5);

    // Oldest note is compared once due; read notes at the accepting edge.
    always @(posedge clk_sys)
        if (q.size() > 0)
            if (q[0].kind == 3'h4 ? (read && !waitrequest) : cyc >= q[0].due)
            begin
                n_compared++;
                if (obs(q[0].kind) !== q[0].val) begin
                    $display("unexpected at %0t exp %h got %h", $time,
                             q[0].val, obs(q[0].kind));
                    err_total++;
                end
                void'(q.pop_front());
            end

    // Main sequence: software mode, pin decode, then link timing.
    initial begin
        ctrl_s       c;
        logic [17:0] v;
        void'($urandom(32'h68593095));
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            c = ctrl_s'(23'($urandom));
            {c.gain_limit, c.e1_t1_select} = i[1:0];
            creg = c;
            bus(1'b1, CTRL_OFFSET, {9'h0, c});
            push(3'h4, {16'h0, c}, 32'h0);
            bus(1'b0, CTRL_OFFSET, 32'h0);
            push(3'h0, full(c, 1'b0), cyc + 32'h1);
            drain();
        end
        push(3'h4, {12'h0, sens_of(c), 2'h0, c}, 32'h0);
        bus(1'b0, STATUS_OFFSET, 32'h0);
        bus(1'b1, 4'h8, $urandom);
        bus(1'b1, STATUS_OFFSET, 32'hFFFF_FFFF);
        push(3'h4, 39'h0, 32'h0);
        bus(1'b0, 4'h8, 32'h0);
        push(3'h4, {16'h0, creg}, 32'h0);
        bus(1'b0, CTRL_OFFSET, 32'h0);
        for (int i = 0; i < 24; i++) begin
            v = 18'($urandom);
            if (i % 4 != 0)
                v[3:2] = 2'b11;
            @(posedge clk_sys);
            pv <= v;
            push(3'h0, full(&v[3:2] ? hwx(v) : creg, &v[3:2]), cyc + 32'h4);
            push(3'h3, {35'h0, ~v[16], ~v[16] & ~v[17], ~v[16],
                 (!(&v[3:2]) && creg.carrier_pin_sel) ? v[0] : v[1]},
                 cyc + 32'h4);
            drain();
        end
        for (int k = 0; k < 4; k++) begin
            v = 18'h0000C;
            v[15:14] = k[1:0];
            v[9:8] = {k[1], k[1] & k[0]};
            @(posedge clk_sys);
            pv <= v;
            repeat (4) @(posedge clk_sys);
            link_on <= 1'b1;
            repeat (100) @(posedge clk_sys);
            link_on <= 1'b0;
            drain();
        end
        conclude();
    end
endmodule
